// ### logic/diag_pkg.sv
/*
  Shared constants for the output fault diagnostic status block: frame
  lengths, operation codes, register offsets, field positions, codes and
  values after reset. Assumes a 24-bit serial frame, command byte first.
*/
package diag_pkg;
  // ****************************************
  // Sizes and frame lengths
  // ****************************************
  localparam int NUM_OUT = 6;
  localparam int NUM_EXT = 2;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] FRAME_LEN = 10'h018;
  localparam logic [CNT_W-1:0] CMD_LEN = 10'h008;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;

  // ****************************************
  // Operation codes and offsets
  // ****************************************
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_READ_CLR = 2'h2;
  localparam logic [1:0] OP_BURST = 2'h3;
  localparam logic [5:0] ADDR_CTRL_LAST = 6'h09;
  localparam logic [5:0] ADDR_CFG_FIRST = 6'h06;
  localparam logic [5:0] ADDR_CFG_LAST = 6'h07;
  localparam logic [5:0] ADDR_OUT_FAULT = 6'h10;
  localparam logic [5:0] ADDR_DYN_STATE = 6'h11;
  localparam logic [5:0] ADDR_DIAG_LAST = 6'h18;
  localparam logic [15:0] CFG_RSVD_MASK = 16'hF000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OF_SPI_BIT = 15;
  localparam int OF_WRT_BIT = 14;
  localparam int OF_RD_BIT = 13;
  localparam int DS_UV_BIT = 15;
  localparam int DS_STAT_LSB = 13;
  localparam int DS_LVL_LSB = 5;
  localparam int DS_EXTF_LSB = 1;
  localparam int GSB_SER_BIT = 5;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_OC = 2'h1;
  localparam logic [1:0] CODE_CNR = 2'h2;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_LSD = 2'h1;
  localparam logic [1:0] EXT_HSD = 2'h2;
  localparam logic [1:0] ACT_READY = 2'h0;
  localparam logic [1:0] ACT_COMPLETE = 2'h3;
  localparam logic [15:0] DIAG_WORD_RST = 16'h0001;
  localparam logic [7:0] GSB_RST = 8'h40;

  // Odd parity: an all-zero word carries a one in bit 0
  function automatic logic [15:0] with_parity(input logic [15:1] bits);
    return {bits, ~(^bits)};
  endfunction
endpackage

// ### logic/fault_code_cell.sv
/*
  One integrated output's 2-bit fault code with latch-off.
  Assumes fault inputs are synchronous to i_core_clk.
*/
`timescale 1ns/1ps
module fault_code_cell
  import diag_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_oc_drive,
  input wire logic i_oc_freewheel,
  input wire logic i_freewheel_phase,
  input wire logic i_on_end,
  input wire logic i_cnr_result,
  input wire logic i_brake_option,
  input wire logic [1:0] i_clear_mask,
  output logic [1:0] o_code,
  output logic o_latched_off
);
  typedef struct packed {
    logic [1:0] code;
  } cell_t;
  cell_t q, d;
  logic oc;

  assign oc = i_oc_drive | (i_oc_freewheel & i_freewheel_phase);

  always_comb begin
    d = q;
    d.code = q.code & ~i_clear_mask;
    if (oc) begin
      d.code = CODE_OC;
    end else if (i_on_end & i_cnr_result & ~i_brake_option &
                 (d.code != CODE_OC)) begin
      d.code = CODE_CNR;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_code = q.code;
  // CURRENT_NOT_REGULATED is report-only; only overcurrent holds the output off
  assign o_latched_off = (q.code == CODE_OC);

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_oc_sets_code: assert property (
    oc |=> (o_code == CODE_OC) && o_latched_off)
    else $error("overcurrent not latched");
  a_oc_priority: assert property (
    (o_code == CODE_OC) && (i_clear_mask == 2'h0) |=> o_code == CODE_OC)
    else $error("overcurrent code lost without clear");
  a_cnr_cause: assert property (
    $rose(o_code == CODE_CNR) |->
      $past(i_on_end & i_cnr_result & ~i_brake_option))
    else $error("cnr posted without end of on phase or with brake");
endmodule

// ### logic/serial_link.sv
/*
  Serial clock domain: frame shifter, edge counter and reply driver.
  Assumes the reply words are held static by the core for the whole frame
  and that chip select falls a few core cycles before the first edge.
*/
`timescale 1ns/1ps
module serial_link
  import diag_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_sys_rst,
  input wire logic i_chip_select_low_n,
  input wire logic i_sdi,
  input wire logic [7:0] i_gsb,
  input wire logic [15:0] i_word_fault,
  input wire logic [15:0] i_word_dyn,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic [23:0] o_rx,
  output logic [CNT_W-1:0] o_cnt,
  output logic o_frame_tog
);
  typedef struct packed {
    logic [23:0] rx;
    logic [7:0] cmd;
    logic [CNT_W-1:0] cnt;
    logic tog;
  } link_t;
  link_t q, d;
  logic armed_q;
  logic [CNT_W-1:0] n, m;
  logic [5:0] a;
  logic [15:0] w;

  // No edge follows the frame, so chip select itself disarms the counter
  always_ff @(posedge i_sclk or posedge i_chip_select_low_n or
              posedge i_sys_rst) begin
    if (i_chip_select_low_n || i_sys_rst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  always_comb begin
    d = q;
    if (!armed_q) begin
      d.cnt = 10'h001;
      d.rx = {q.rx[22:0], i_sdi};
      d.tog = ~q.tog;
    end else begin
      if (q.cnt != CNT_MAX) begin
        d.cnt = q.cnt + 10'h001;
      end
      if (q.cnt < FRAME_LEN) begin
        d.rx = {q.rx[22:0], i_sdi};
      end
      if (q.cnt == CMD_LEN - 10'h001) begin
        d.cmd = {q.rx[6:0], i_sdi};
      end
    end
  end

  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Reply: status byte, then payload words
  // ****************************************
  assign n = armed_q ? q.cnt : '0;
  assign m = n - CMD_LEN;
  assign a = q.cmd[5:0] + m[CNT_W-1:4];
  assign w = (a == ADDR_OUT_FAULT) ? i_word_fault :
             (a == ADDR_DYN_STATE) ? i_word_dyn : 16'h0000;
  assign o_sdo = (n < CMD_LEN) ? i_gsb[~n[2:0]] : w[~m[3:0]];
  assign o_sdo_oe = ~i_chip_select_low_n;
  assign o_rx = q.rx;
  assign o_cnt = q.cnt;
  assign o_frame_tog = q.tog;

  a_count_start: assert property (
    @(posedge i_sclk) disable iff (i_sys_rst)
    !armed_q |=> q.cnt == 10'h001)
    else $error("edge count did not restart at frame start");
endmodule

// ### logic/output_fault_diag_status.sv
/*
  Output fault and dynamic state diagnostic registers behind a 24-bit
  serial port, with frame, write and read error flags.
  Assumes fault events are synchronous to i_core_clk, level pins and
  chip select are asynchronous, and the serial clock stops between frames.
*/
// Behaviour
// - Latched faults stay until read-and-clear
// - Output code: none, overcurrent, not regulated
// - Post not-regulated at end of on phase
// - Overcurrent flags and latches output off
// - Overcurrent blocks not-regulated until cleared
// - Not-regulated only reports, never disables
// - No not-regulated report with brake option
// - Overcurrent from driving or shorted freewheel
// - Bad read address sets read error only
// - Frame error on count, stuck, parity
// - Normal frame needs exactly 24 edges
// - Burst frame is 8 plus 16n edges
// - Errored frame changes no register but the frame error flag
// - Bad config data stored, write error set
// - Write outside 00H-09H sets write error
// - Levels sampled at chip select fall
// - Fault register bit layout
// - Dynamic state register bit layout
// - Levels read-only; other state bits clearable
// - Reset: all zero, parity one
// - Serial summary ORs errors, clears with them
// - Fault summary ORs overcurrent and drain faults
// - External code: none, low, high side
// - Actuation state holds complete until cleared
`timescale 1ns/1ps
module output_fault_diag_status
  import diag_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_chip_select_low_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic [NUM_OUT-1:0] i_oc_drive,
  input wire logic [NUM_OUT-1:0] i_oc_freewheel,
  input wire logic [NUM_OUT-1:0] i_freewheel_phase,
  input wire logic [NUM_OUT-1:0] i_on_end,
  input wire logic [NUM_OUT-1:0] i_cnr_result,
  input wire logic [NUM_OUT-1:0] i_brake_option,
  input wire logic [NUM_OUT-1:0] i_out_level,
  input wire logic [NUM_EXT-1:0] i_ext_level,
  input wire logic [NUM_EXT-1:0] i_ext_lsd_fault,
  input wire logic [NUM_EXT-1:0] i_ext_hsd_fault,
  input wire logic i_vdd_uv,
  input wire logic [1:0] i_act_state,
  input wire logic i_supply_fault,
  input wire logic i_device_error,
  input wire logic i_global_warning,
  output logic [NUM_OUT-1:0] o_output_off,
  output logic o_cfg_wr,
  output logic [5:0] o_cfg_addr,
  output logic [15:0] o_cfg_data
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic csn_s1;
    logic csn_s2;
    logic csn_s3;
    logic tog_s1;
    logic tog_s2;
    logic tog_start;
    logic [7:0] lvl_s1;
    logic [7:0] lvl_s2;
    logic spi_fail;
    logic write_error_flag;
    logic rd_fail;
    logic wrt_pend;
    logic reset_flag;
    logic vdd_uv;
    logic [1:0] act_state;
    logic [3:0] ext_fault;
    logic [15:0] snap_fault;
    logic [15:0] snap_dyn;
    logic [7:0] snap_gsb;
    logic cfg_wr;
    logic [5:0] cfg_addr;
    logic [15:0] cfg_data;
  } core_t;

  localparam core_t CORE_RST = '{csn_s1: 1'b1, csn_s2: 1'b1,
    csn_s3: 1'b1, reset_flag: 1'b1, snap_fault: DIAG_WORD_RST,
    snap_dyn: DIAG_WORD_RST, snap_gsb: GSB_RST, default: '0};

  core_t q, d;
  logic [23:0] link_rx;
  logic [CNT_W-1:0] link_cnt;
  logic link_tog;
  logic [2*NUM_OUT-1:0] codes;
  logic [2*NUM_OUT-1:0] code_clr;
  logic [15:0] fault_word, dyn_word, flag_clr, dyn_clr;
  logic [7:0] gsb;
  logic [6:0] gsb_low;
  logic cs_fall, cs_rise, got_edges, len_ok, stuck, par_ok, frame_bad;
  logic frame_ok, rc_fault, ser_sum, fe1;
  logic [1:0] op;
  logic [5:0] addr;
  logic [15:0] data;

  function automatic logic readable(input logic [5:0] a);
    return (a <= ADDR_CTRL_LAST) ||
           ((a >= ADDR_OUT_FAULT) && (a <= ADDR_DIAG_LAST));
  endfunction

  function automatic logic burst_len_ok(input logic [CNT_W-1:0] c);
    logic [CNT_W-1:0] p;
    p = c - CMD_LEN;
    return (c >= FRAME_LEN) && (p[3:0] == 4'h0) && (c != CNT_MAX);
  endfunction

  function automatic logic any_oc(input logic [2*NUM_OUT-1:0] c);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) begin
      r = r | (c[2*i +: 2] == CODE_OC);
    end
    return r;
  endfunction

  // ****************************************
  // Serial link and output cells
  // ****************************************
  serial_link u_link (
    .i_sclk(i_sclk),
    .i_sys_rst(i_sys_rst),
    .i_chip_select_low_n(i_chip_select_low_n),
    .i_sdi(i_sdi),
    .i_gsb(q.snap_gsb),
    .i_word_fault(q.snap_fault),
    .i_word_dyn(q.snap_dyn),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe),
    .o_rx(link_rx),
    .o_cnt(link_cnt),
    .o_frame_tog(link_tog)
  );

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_cell
    fault_code_cell u_cell (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_oc_drive(i_oc_drive[g]),
      .i_oc_freewheel(i_oc_freewheel[g]),
      .i_freewheel_phase(i_freewheel_phase[g]),
      .i_on_end(i_on_end[g]),
      .i_cnr_result(i_cnr_result[g]),
      .i_brake_option(i_brake_option[g]),
      .i_clear_mask(code_clr[2*g +: 2]),
      .o_code(codes[2*g +: 2]),
      .o_latched_off(o_output_off[g])
    );
  end

  // ****************************************
  // Frame decode at chip select rise
  // ****************************************
  // Link words are static once the serial clock has stopped; the
  // synchronised chip select edge acts as their handshake
  assign cs_fall = q.csn_s3 & ~q.csn_s2;
  assign cs_rise = ~q.csn_s3 & q.csn_s2;
  assign op = link_rx[23:22];
  assign addr = link_rx[21:16];
  assign data = link_rx[15:0];
  assign got_edges = q.tog_s2 != q.tog_start;
  assign len_ok = got_edges && ((op == OP_BURST) ? burst_len_ok(link_cnt)
                                : (link_cnt == FRAME_LEN));
  assign stuck = (link_rx == '0) || (link_rx == '1);
  assign par_ok = ^link_rx;
  assign frame_bad = !len_ok || stuck || !par_ok;
  assign frame_ok = cs_rise && !frame_bad;
  assign rc_fault = frame_ok && (op == OP_READ_CLR) &&
                    (addr == ADDR_OUT_FAULT);
  // Only bits the host has seen may be cleared
  assign flag_clr = data & q.snap_fault;
  assign dyn_clr = data & q.snap_dyn;
  assign code_clr = rc_fault ? flag_clr[12:1] : '0;

  // ****************************************
  // Register views
  // ****************************************
  assign fault_word = with_parity({q.spi_fail, q.write_error_flag, q.rd_fail,
                                   codes});
  assign dyn_word = with_parity({q.vdd_uv, q.act_state, q.lvl_s2,
                                 q.ext_fault});
  assign ser_sum = q.spi_fail | q.write_error_flag | q.rd_fail;
  assign fe1 = any_oc(codes) | (|q.ext_fault);
  assign gsb_low = {q.reset_flag, ser_sum, i_supply_fault | q.vdd_uv, fe1,
                    i_device_error, i_global_warning, 1'b0};
  assign gsb = {~(|gsb_low), gsb_low};

  always_comb begin
    d = q;
    d.csn_s1 = i_chip_select_low_n;
    d.csn_s2 = q.csn_s1;
    d.csn_s3 = q.csn_s2;
    d.tog_s1 = link_tog;
    d.tog_s2 = q.tog_s1;
    d.lvl_s1 = {i_ext_level, i_out_level};
    d.lvl_s2 = q.lvl_s1;
    d.cfg_wr = 1'b0;
    if (cs_fall) begin
      d.tog_start = q.tog_s2;
      d.snap_fault = fault_word;
      d.snap_dyn = dyn_word;
      d.snap_gsb = gsb;
    end
    if (cs_rise) begin
      if (frame_bad) begin
        d.spi_fail = 1'b1;
      end else begin
        d.reset_flag = 1'b0;
        case (op)
          OP_WRITE: begin
            if (addr <= ADDR_CTRL_LAST) begin
              d.cfg_wr = 1'b1;
              d.cfg_addr = addr;
              d.cfg_data = data;
              if ((addr >= ADDR_CFG_FIRST) && (addr <= ADDR_CFG_LAST)) begin
                // Bad data is still stored; the flag waits for good data
                if (|(data & CFG_RSVD_MASK)) begin
                  d.write_error_flag = 1'b1;
                  d.wrt_pend = 1'b1;
                end else begin
                  d.wrt_pend = 1'b0;
                end
              end
            end else begin
              d.write_error_flag = 1'b1;
            end
          end
          OP_READ, OP_BURST: begin
            if (!readable(addr)) begin
              d.rd_fail = 1'b1;
            end
          end
          OP_READ_CLR: begin
            if (!readable(addr)) begin
              d.rd_fail = 1'b1;
            end else if (addr == ADDR_OUT_FAULT) begin
              if (flag_clr[OF_SPI_BIT]) begin
                d.spi_fail = 1'b0;
              end
              if (flag_clr[OF_RD_BIT]) begin
                d.rd_fail = 1'b0;
              end
              if (flag_clr[OF_WRT_BIT] && !q.wrt_pend) begin
                d.write_error_flag = 1'b0;
              end
            end else if (addr == ADDR_DYN_STATE) begin
              if (dyn_clr[DS_UV_BIT]) begin
                d.vdd_uv = 1'b0;
              end
              d.act_state = q.act_state &
                            ~dyn_clr[DS_STAT_LSB +: 2];
              d.ext_fault = q.ext_fault & ~dyn_clr[DS_EXTF_LSB +: 4];
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Hardware events last, so a set in the clearing cycle survives
    if (i_vdd_uv) begin
      d.vdd_uv = 1'b1;
    end
    for (int k = 0; k < NUM_EXT; k++) begin
      if (d.ext_fault[2*k +: 2] == EXT_NONE) begin
        if (i_ext_lsd_fault[k]) begin
          d.ext_fault[2*k +: 2] = EXT_LSD;
        end else if (i_ext_hsd_fault[k]) begin
          d.ext_fault[2*k +: 2] = EXT_HSD;
        end
      end
    end
    if (d.act_state != ACT_COMPLETE) begin
      d.act_state = i_act_state;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign o_cfg_wr = q.cfg_wr;
  assign o_cfg_addr = q.cfg_addr;
  assign o_cfg_data = q.cfg_data;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_bad_end;
    cs_rise && frame_bad;
  endsequence
  sequence s_good_end(logic [1:0] o);
    cs_rise && !frame_bad && (op == o);
  endsequence

  a_frame_err_flag: assert property (
    s_bad_end |=> q.spi_fail ##1 q.spi_fail)
    else $error("frame error not flagged");
  a_frame_err_quiet: assert property (
    s_bad_end |=> !q.cfg_wr && $stable(q.write_error_flag) && $stable(q.rd_fail))
    else $error("errored frame changed state");
  a_count_exact: assert property (
    cs_rise && (op != OP_BURST) && (link_cnt != FRAME_LEN) |=> q.spi_fail)
    else $error("wrong edge count accepted");
  a_read_fail: assert property (
    s_good_end(OP_READ) and !readable(addr) |=> q.rd_fail && !q.cfg_wr)
    else $error("bad read address not flagged");
  a_write_range: assert property (
    s_good_end(OP_WRITE) and (addr > ADDR_CTRL_LAST) |=>
      q.write_error_flag && !q.cfg_wr)
    else $error("write outside range not flagged");
  a_sample_fall: assert property (
    cs_fall |=> q.snap_dyn[DS_LVL_LSB +: 8] == $past(q.lvl_s2))
    else $error("levels not sampled at chip select fall");
  a_flag_sticky: assert property (
    q.rd_fail && !(cs_rise && !frame_bad && (op == OP_READ_CLR)) |=>
      q.rd_fail)
    else $error("read error cleared without read-and-clear");
  a_reset_words: assert property (
    $past(i_sys_rst) |-> (fault_word == DIAG_WORD_RST) &&
      (dyn_word == DIAG_WORD_RST))
    else $error("diagnostic words wrong after reset");
  a_complete_hold: assert property (
    (q.act_state == ACT_COMPLETE) && !cs_rise |=>
      q.act_state == ACT_COMPLETE)
    else $error("complete state left without clear");
endmodule

// ### tb/serial_host_model.sv
/*
  Serial host model: sends frames of a chosen clock count, MSB first,
  and collects the reply. Assumes the device samples data on the rising
  serial clock edge and updates its reply after it.
*/
`timescale 1ns/1ps
module serial_host_model (
  output logic o_sclk,
  output logic o_chip_select_low_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  // ****************************************
  // Frame driver
  // ****************************************
  initial begin
    o_sclk = 1'b0;
    o_chip_select_low_n = 1'b1;
    o_sdi = 1'b0;
  end

  // Clock stands low between frames; released data line shows inverse
  task automatic xfer(input int n, input logic [23:0] tx,
    output logic [23:0] rx);
    rx = 24'h000000;
    o_chip_select_low_n = 1'b0;
    #40;
    for (int k = 0; k < n; k++) begin
      // Burst payload clocks carry no command bits
      o_sdi = (k < 24) ? tx[23-k] : 1'b0;
      #20;
      rx = {rx[22:0], i_sdo};
      o_sclk = 1'b1;
      #40;
      o_sclk = 1'b0;
      #20;
    end
    #20;
    o_chip_select_low_n = 1'b1;
    o_sdi = ~o_sdi;
    // Gap well above the four core cycles between frames
    #100;
  endtask
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench for the diagnostic status block: reset values,
  output faults, serial errors and the dynamic state register.
  Assumes the serial host model and the design package.
*/
`timescale 1ns/1ps
module tb_top
  import diag_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b0;
  logic i_sclk, i_chip_select_low_n, i_sdi, o_sdo, o_sdo_oe, o_cfg_wr;
  logic [NUM_OUT-1:0] i_oc_drive, i_oc_freewheel, i_freewheel_phase;
  logic [NUM_OUT-1:0] i_on_end, i_cnr_result, i_brake_option;
  logic [NUM_OUT-1:0] i_out_level, o_output_off;
  logic [NUM_EXT-1:0] i_ext_level, i_ext_lsd_fault, i_ext_hsd_fault;
  logic i_vdd_uv, i_supply_fault, i_device_error, i_global_warning;
  logic [1:0] i_act_state;
  logic [5:0] o_cfg_addr;
  logic [15:0] o_cfg_data;
  logic [23:0] rx;
  int bad_count = 0;
  int samples_checked = 0;
  int wr_pulses = 0;
  int oe_errs = 0;

  // ****************************************
  // Design, host and clocks
  // ****************************************
  output_fault_diag_status dut_u (.i_core_clk, .i_sys_rst, .i_sclk,
    .i_chip_select_low_n, .i_sdi, .o_sdo, .o_sdo_oe, .i_oc_drive,
    .i_oc_freewheel, .i_freewheel_phase, .i_on_end, .i_cnr_result,
    .i_brake_option, .i_out_level, .i_ext_level, .i_ext_lsd_fault,
    .i_ext_hsd_fault, .i_vdd_uv, .i_act_state, .i_supply_fault,
    .i_device_error, .i_global_warning, .o_output_off, .o_cfg_wr,
    .o_cfg_addr, .o_cfg_data);
  serial_host_model host_u (.o_sclk(i_sclk),
    .o_chip_select_low_n(i_chip_select_low_n), .o_sdi(i_sdi),
    .i_sdo(o_sdo));

  always #2.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    if (o_cfg_wr === 1'b1) begin
      wr_pulses <= wr_pulses + 1;
    end
    if (o_sdo_oe !== ~i_chip_select_low_n) begin
      oe_errs <= oe_errs + 1;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [23:0] exp,
    input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Odd parity over the whole frame
  function automatic logic [23:0] fr(input logic [1:0] op,
    input logic [5:0] a, input logic [15:0] d);
    logic [22:0] b;
    b = {op, a, d[15:1]};
    return {b, ~(^b)};
  endfunction

  task automatic xf(input logic [1:0] op, input logic [5:0] a,
    input logic [15:0] d);
    host_u.xfer(24, fr(op, a, d), rx);
    step(1);
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    xf(OP_READ, ADDR_OUT_FAULT, 16'h0000);
    chk("reset_fault", 24'h400001, rx);
    host_u.xfer(40, fr(OP_BURST, ADDR_OUT_FAULT, 16'h0000), rx);
    step(1);
    chk("burst", 24'h010001, rx);
    xf(OP_READ, ADDR_DYN_STATE, 16'h0000);
    chk("reset_dyn", 24'h800001, rx);
  endtask

  task automatic t_output_faults;
    i_oc_drive = 6'h01;
    i_oc_freewheel = 6'h30;
    i_freewheel_phase = 6'h20;
    step(1);
    i_oc_drive = 6'h00;
    i_oc_freewheel = 6'h00;
    i_on_end = 6'h07;
    i_cnr_result = 6'h07;
    i_brake_option = 6'h04;
    step(1);
    i_on_end = 6'h00;
    step(3);
    chk("output_off", 24'h000021, {18'h00000, o_output_off});
    xf(OP_READ, ADDR_OUT_FAULT, 16'h0000);
    chk("fault_word", 24'h080812, rx);
    chk("master_codes", 24'h000001, {20'h0, rx[8:7], rx[2:1]});
    xf(OP_READ, ADDR_OUT_FAULT, 16'h0000);
    chk("fault_kept", 24'h080812, rx);
    xf(OP_READ_CLR, ADDR_OUT_FAULT, 16'hFFFE);
    chk("fault_rc", 24'h080812, rx);
    xf(OP_READ, ADDR_OUT_FAULT, 16'h0000);
    chk("fault_clr", 24'h800001, rx);
    chk("output_on", 24'h000000, {18'h00000, o_output_off});
  endtask

  task automatic t_serial_errors;
    logic [23:0] f;
    f = fr(OP_WRITE, ADDR_CFG_LAST, 16'hF0F0);
    host_u.xfer(23, fr(OP_WRITE, ADDR_CFG_FIRST, 16'h0010), rx);
    step(1);
    host_u.xfer(24, fr(OP_WRITE, 6'h06, 16'h0010) ^ 24'h000001, rx);
    step(1);
    xf(OP_READ, 6'h3F, 16'h0000);
    xf(OP_WRITE, 6'h0A, 16'h0000);
    chk("cfg_none", 24'h000000, wr_pulses[23:0]);
    xf(OP_READ, ADDR_OUT_FAULT, 16'h0000);
    chk("err_word", 24'h20E000, rx);
    host_u.xfer(24, f, rx);
    step(1);
    chk("cfg_store", {8'h07, f[15:0]}, {2'h0, o_cfg_addr, o_cfg_data});
    xf(OP_WRITE, ADDR_CFG_FIRST, 16'h0122);
    chk("cfg_count", 24'h000002, wr_pulses[23:0]);
    xf(OP_READ_CLR, ADDR_OUT_FAULT, 16'hFFFE);
    chk("err_rc", 24'h20E000, rx);
    xf(OP_READ, ADDR_OUT_FAULT, 16'h0000);
    chk("err_clr", 24'h800001, rx);
  endtask

  task automatic t_dyn_state;
    i_out_level = 6'h2A;
    i_ext_level = 2'h1;
    i_act_state = 2'h3;
    i_vdd_uv = 1'b1;
    i_ext_hsd_fault = 2'h2;
    i_ext_lsd_fault = 2'h1;
    step(1);
    i_vdd_uv = 1'b0;
    i_ext_hsd_fault = 2'h0;
    i_ext_lsd_fault = 2'h0;
    step(2);
    // Live state drops back; register must hold complete
    i_act_state = 2'h1;
    step(4);
    xf(OP_READ, ADDR_DYN_STATE, 16'h0000);
    chk("dyn_word", 24'h18ED52, rx);
    xf(OP_READ_CLR, ADDR_DYN_STATE, 16'hFFFE);
    chk("dyn_rc", 24'h18ED52, rx);
    xf(OP_READ, ADDR_DYN_STATE, 16'h0000);
    chk("dyn_clr", 24'h802D40, rx);
    chk("sdo_oe", 24'h000000, oe_errs[23:0]);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_oc_drive, i_oc_freewheel, i_freewheel_phase} = 18'h00000;
    {i_on_end, i_cnr_result, i_brake_option, i_out_level} = 24'h000000;
    {i_ext_level, i_ext_lsd_fault, i_ext_hsd_fault} = 6'h00;
    {i_vdd_uv, i_supply_fault, i_device_error, i_global_warning} = 4'h0;
    i_act_state = 2'h0;
    // A real edge, so the link side's asynchronous reset takes effect
    #1;
    i_sys_rst = 1'b1;
    step(10);
    i_sys_rst = 1'b0;
    step(4);
    t_reset();
    t_output_faults();
    t_serial_errors();
    t_dyn_state();
    end_of_test();
  end
endmodule
